// ---- bench/stc_pin_model.sv ----
`timescale 1ns/1ps
module stc_pin_model
(
  input wire mclk,
  input wire fallReq,
  output wire pinOut
);
  reg [4:0] lowCnt_ff = 5'h00;
  // Low over two samples so one fall is seen exactly once
  assign pinOut = lowCnt_ff == 5'h00;
  always @(posedge mclk)
    lowCnt_ff <= fallReq ? 5'h1e : lowCnt_ff - {4'h0, lowCnt_ff != 5'h00};
endmodule

// ---- bench/stc_timer_checker.sv ----
`timescale 1ns/1ps
module stc_timer_checker
(
  input wire mclk,
  input wire reset_n,
  input wire [7:0] sfrAddr,
  input wire sfrWrEn,
  input wire timerOneOverflowIn,
  input wire timerOneRunEff,
  input wire irqTimerZero,
  input wire irqTimerOne,
  input wire irqTimerTwo,
  input wire timerTwoOverflow,
  input wire rxBaudTick,
  input wire txBaudTick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Software writes, the only way a flag may drop or the timer one effective run may change
  wire wrT2 = sfrWrEn && sfrAddr == 8'hc8;
  wire wrTc = sfrWrEn && sfrAddr == 8'hd0;
  wire wrTm = sfrWrEn && (sfrAddr == 8'hd0 || sfrAddr == 8'hd1);
  property p_ovfGap;
    timerTwoOverflow |=> !timerTwoOverflow [*8];
  endproperty
  a_ovfGap: assert property (p_ovfGap) else $error("rollovers too close");
  property p_rxSrc;
    rxBaudTick && !timerTwoOverflow |-> $past(timerOneOverflowIn);
  endproperty
  a_rxSrc: assert property (p_rxSrc) else $error("stray receive tick");
  property p_txSrc;
    txBaudTick && !timerTwoOverflow |-> $past(timerOneOverflowIn);
  endproperty
  a_txSrc: assert property (p_txSrc) else $error("stray transmit tick");
  property p_irq2Set;
    timerTwoOverflow && !rxBaudTick && !txBaudTick |-> ##[1:2] irqTimerTwo;
  endproperty
  a_irq2Set: assert property (p_irq2Set) else $error("no timer two request");
  property p_irq2Clr;
    $fell(irqTimerTwo) |-> $past(wrT2, 2);
  endproperty
  a_irq2Clr: assert property (p_irq2Clr) else $error("timer two flag lost");
  property p_irq1Clr;
    $fell(irqTimerOne) |-> $past(wrTc, 2);
  endproperty
  a_irq1Clr: assert property (p_irq1Clr) else $error("timer one flag lost");
  property p_irq0Clr;
    $fell(irqTimerZero) |-> $past(wrTc, 2);
  endproperty
  a_irq0Clr: assert property (p_irq0Clr) else $error("timer zero flag lost");
  property p_runEff;
    $changed(timerOneRunEff) |-> $past(wrTm) || $past(wrTm, 2);
  endproperty
  a_runEff: assert property (p_runEff) else $error("timer one run moved");
endmodule
bind stc_timer stc_timer_checker i_stc_timer_checker
(
  .mclk, .reset_n, .sfrAddr, .sfrWrEn, .timerOneOverflowIn, .timerOneRunEff,
  .irqTimerZero, .irqTimerOne, .irqTimerTwo, .timerTwoOverflow, .rxBaudTick, .txBaudTick
);

// ---- bench/stc_timer_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin badCount++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module stc_timer_tb_top;
  reg mclk;
  reg reset_n = 1'b0;
  reg [7:0] sfrAddr = 8'h00;
  reg [7:0] sfrWrData = 8'h00;
  reg sfrWrEn = 1'b0;
  reg sfrRdEn = 1'b0;
  reg t1Ovf = 1'b0;
  reg trgReq = 1'b0;
  reg cntReq = 1'b0;
  reg gatePin = 1'b1;
  wire trgPin, cntPin, runEff, irq0, irq1, irq2, ovf2, rxTick, txTick;
  wire [7:0] rdData;
  integer badCount = 0;
  integer compares = 0;
  // Timer zero shares the event pin; timer two is stopped in split tests
  stc_timer i_stc_timer
  (
    .mclk(mclk), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrRdData(rdData), .timerZeroPin(cntPin),
    .external_gate_input_zero(gatePin), .timerTwoPin(cntPin), .trigger_input_pin(trgPin),
    .timerOneOverflowIn(t1Ovf), .timerOneRunEff(runEff), .irqTimerZero(irq0),
    .irqTimerOne(irq1), .irqTimerTwo(irq2), .timerTwoOverflow(ovf2),
    .rxBaudTick(rxTick), .txBaudTick(txTick)
  );
  stc_pin_model i_stc_pin_model (.mclk(mclk), .fallReq(trgReq), .pinOut(trgPin));
  stc_pin_model i_stc_pin_model_cnt (.mclk(mclk), .fallReq(cntReq), .pinOut(cntPin));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      @(negedge mclk);
      sfrWrEn = 1'b0;
    end
  endtask
  // Read data lands one edge after the strobe
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge mclk);
      sfrAddr = a;
      sfrRdEn = 1'b1;
      @(negedge mclk);
      sfrRdEn = 1'b0;
      `CHK(rdData, e)
    end
  endtask
  // One pin fall, then room for two clean machine-cycle samples
  task fall(input trg);
    begin
      @(negedge mclk);
      trgReq = trg;
      cntReq = !trg;
      @(negedge mclk);
      trgReq = 1'b0;
      cntReq = 1'b0;
      repeat (60) @(negedge mclk);
    end
  endtask
  task waitOvf;
    integer n;
    begin
      n = 0;
      while (ovf2 !== 1'b1 && n < 400)
      begin
        @(negedge mclk);
        n++;
      end
      if (ovf2 !== 1'b1)
      begin
        badCount++;
        wrapUp;
      end
    end
  endtask
  task tReset;
    begin
      rd(8'hc8, 8'h00);
      wr(8'hd6, 8'ha5);
      rd(8'hd6, 8'ha5);
      rd(8'he0, 8'h00);
    end
  endtask
  task tReload;
    begin
      wr(8'hd6, 8'hfe);
      wr(8'hd7, 8'hff);
      wr(8'hd4, 8'hfe);
      wr(8'hd5, 8'hff);
      wr(8'hc8, 8'h04);
      waitOvf;
      rd(8'hd4, 8'hfe);
      rd(8'hc8, 8'h84);
      `CHK(irq2, 1'b1)
      wr(8'hc8, 8'h00);
      repeat (40) @(negedge mclk);
      rd(8'hd4, 8'hfe);
    end
  endtask
  task tTrigger;
    begin
      wr(8'hd4, 8'h00);
      wr(8'hd5, 8'h12);
      wr(8'hc8, 8'h0d);
      fall(1'b1);
      rd(8'hd7, 8'h12);
      rd(8'hc8, 8'h4d);
      wr(8'hd7, 8'h34);
      wr(8'hd5, 8'h00);
      wr(8'hc8, 8'h0c);
      fall(1'b1);
      rd(8'hd5, 8'h34);
      rd(8'hc8, 8'h4c);
      wr(8'hc8, 8'h04);
      fall(1'b1);
      rd(8'hc8, 8'h04);
      wr(8'hc8, 8'h3c);
      fall(1'b1);
      rd(8'hc8, 8'h3c);
    end
  endtask
  // Stopped first so no rollover slips in under the old mode
  task tBaud;
    reg [7:0] k;
    begin
      wr(8'hc8, 8'h00);
      wr(8'hd6, 8'hff);
      wr(8'hd7, 8'hff);
      wr(8'hd4, 8'hff);
      wr(8'hd5, 8'hff);
      // Capture select set: baud mode must still reload on rollover
      for (k = 8'h15; k < 8'h40; k = k + 8'h10)
      begin
        wr(8'hc8, k);
        @(negedge mclk);
        waitOvf;
        `CHK({rxTick, txTick}, k[5:4])
        @(negedge mclk);
        `CHK(ovf2, 1'b0)
      end
      rd(8'hc8, 8'h35);
      rd(8'hd5, 8'hff);
      wr(8'hc8, 8'h00);
      @(negedge mclk);
      t1Ovf = 1'b1;
      @(negedge mclk);
      `CHK({rxTick, txTick}, 2'h3)
      t1Ovf = 1'b0;
    end
  endtask
  task tCounter;
    begin
      wr(8'hd4, 8'h00);
      wr(8'hd5, 8'h00);
      wr(8'hc8, 8'h06);
      repeat (3) fall(1'b0);
      rd(8'hd4, 8'h03);
      wr(8'hc8, 8'h00);
    end
  endtask
  task tSplit;
    begin
      wr(8'hd1, 8'h03);
      wr(8'hd3, 8'hfe);
      wr(8'hd0, 8'h40);
      repeat (40) @(negedge mclk);
      `CHK(irq1, 1'b1)
      `CHK(runEff, 1'b0)
      wr(8'hd0, 8'h00);
      wr(8'hd2, 8'hff);
      wr(8'hd0, 8'h10);
      repeat (20) @(negedge mclk);
      `CHK(irq0, 1'b1)
      rd(8'hd0, 8'h30);
      // Gated pin counting: low gate blocks events
      wr(8'hd1, 8'h0f);
      wr(8'hd2, 8'h00);
      wr(8'hd0, 8'h10);
      gatePin = 1'b0;
      fall(1'b0);
      rd(8'hd2, 8'h00);
      gatePin = 1'b1;
      repeat (2) fall(1'b0);
      rd(8'hd2, 8'h02);
      wr(8'hd1, 8'h00);
      wr(8'hd0, 8'h40);
      repeat (3) @(negedge mclk);
      `CHK(runEff, 1'b1)
    end
  endtask
  task wrapUp;
    begin
      $display("compares %0d bad_count %0d", compares, badCount);
      if (badCount == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    tReset;
    tReload;
    tTrigger;
    tBaud;
    tCounter;
    tSplit;
    wrapUp;
  end
endmodule

// ---- verilog/stc_defs.vh ----
`ifndef STC_DEFS_VH
`define STC_DEFS_VH
// Overview of operation
// - Split mode holds timer one stopped
// - Split mode: two independent 8-bit timer zero bytes
// - High byte counts cycles, run/flag of timer one
// - Timer two: 16-bit up, pin edges or cycles
// - Overflow flag set unless serial clock selected
// - External flag set on trigger capture/reload
// - Both timer two flags share one interrupt
// - Receive clock source selects timer two overflow
// - Transmit clock source selects timer two overflow
// - Trigger enable gates trigger edges, not baud
// - Run bit starts and stops timer two
// - Capture/reload select, ignored in baud mode
// - Capture mode without trigger: plain 16-bit timer
// - Trigger fall captures timer into reload pair
// - Rollover sets flag and reloads from pair
// - Trigger fall forces early reload, sets flag
// - Either clock source bit selects baud mode
// - Input sampled per machine cycle, high-then-low

// Special function register addresses
`define STC_ADDR_T2CTRL 8'hc8
`define STC_ADDR_TCTRL 8'hd0
`define STC_ADDR_TMODE 8'hd1
`define STC_ADDR_T0LOW 8'hd2
`define STC_ADDR_T0HIGH 8'hd3
`define STC_ADDR_T2LOW 8'hd4
`define STC_ADDR_T2HIGH 8'hd5
`define STC_ADDR_CRLOW 8'hd6
`define STC_ADDR_CRHIGH 8'hd7

// Timer two control fields
`define STC_T2_OVF 7
`define STC_T2_EXF 6
`define STC_T2_RXSRC 5
`define STC_T2_TXSRC 4
`define STC_T2_EXEN 3
`define STC_T2_RUN 2
`define STC_T2_CT 1
`define STC_T2_CPRL 0

// Timer zero/one control fields
`define STC_TC_OVF1 7
`define STC_TC_RUN1 6
`define STC_TC_OVF0 5
`define STC_TC_RUN0 4

// Timer mode fields, timer zero half
`define STC_TM_GATE0 3
`define STC_TM_CT0 2
`define STC_TM_MODE0_HI 1
`define STC_TM_MODE0_LO 0
`define STC_TM_SPLIT 2'h3

// Reset values
`define STC_RST_BYTE 8'h00
`define STC_RST_WORD 16'h0000

// Oscillator clocks per machine cycle
`define STC_MC_DIV 12
`define STC_MC_CNT_W 4
`define STC_MC_LAST 4'hb
`endif

// ---- verilog/stc_edge_sampler.v ----
`timescale 1ns/1ps
module stc_edge_sampler
(
  mclk,
  reset_n,
  pinIn,
  sampleTick,
  pinLevel,
  fallEvent
);
  input wire mclk;
  input wire reset_n;
  input wire pinIn;
  input wire sampleTick;
  output wire pinLevel;
  output wire fallEvent;

  reg syncA_ff;
  reg syncB_ff;
  reg smpNow_ff;
  reg fall_ff;

  // Two-stage synchroniser; first stage feeds only the second
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      syncA_ff <= 1'b1;
      syncB_ff <= 1'b1;
    end
    else
    begin
      syncA_ff <= pinIn;
      syncB_ff <= syncA_ff;
    end
  end

  // One sample per machine cycle, fall on high then low
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      smpNow_ff <= 1'b1;
      fall_ff <= 1'b0;
    end
    else
    begin
      fall_ff <= sampleTick & smpNow_ff & ~syncB_ff;
      if (sampleTick)
        smpNow_ff <= syncB_ff;
    end
  end

  assign pinLevel = syncB_ff;
  assign fallEvent = fall_ff;
endmodule

// ---- verilog/stc_timer.v ----
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_timer
(
  mclk,
  reset_n,
  sfrAddr,
  sfrWrData,
  sfrWrEn,
  sfrRdEn,
  sfrRdData,
  timerZeroPin,
  external_gate_input_zero,
  timerTwoPin,
  trigger_input_pin,
  timerOneOverflowIn,
  timerOneRunEff,
  irqTimerZero,
  irqTimerOne,
  irqTimerTwo,
  timerTwoOverflow,
  rxBaudTick,
  txBaudTick
);
  input wire mclk;
  input wire reset_n;
  input wire [7:0] sfrAddr;
  input wire [7:0] sfrWrData;
  input wire sfrWrEn;
  input wire sfrRdEn;
  output wire [7:0] sfrRdData;
  input wire timerZeroPin;
  input wire external_gate_input_zero;
  input wire timerTwoPin;
  input wire trigger_input_pin;
  input wire timerOneOverflowIn;
  output wire timerOneRunEff;
  output wire irqTimerZero;
  output wire irqTimerOne;
  output wire irqTimerTwo;
  output wire timerTwoOverflow;
  output wire rxBaudTick;
  output wire txBaudTick;

  localparam [`STC_MC_CNT_W-1:0] MC_LAST = `STC_MC_LAST;
  localparam PIN_T0 = 0;
  localparam PIN_GATE0 = 1;
  localparam PIN_T2 = 2;
  localparam PIN_TRIG = 3;

  reg [`STC_MC_CNT_W-1:0] mcCnt_ff;
  reg mcTick_ff;
  reg [7:0] second_timer_control_ff;
  reg [7:0] tCtrl_ff;
  reg [3:0] tMode_ff;
  reg [7:0] timer_zero_low_byte_ff;
  reg [7:0] timer_zero_high_byte_ff;
  reg [7:0] timer_two_low_byte_ff;
  reg [7:0] timer_two_high_byte_ff;
  reg [7:0] capture_reload_low_ff;
  reg [7:0] capture_reload_high_ff;
  reg [7:0] rdData_ff;
  reg t1RunEff_ff;
  reg irq0_ff;
  reg irq1_ff;
  reg irq2_ff;
  reg t2Ovf_ff;
  reg rxTick_ff;
  reg txTick_ff;

  reg [7:0] nxt_t2Ctrl;
  reg [7:0] nxt_tCtrl;
  reg [7:0] nxt_t0Low;
  reg [7:0] nxt_t0High;
  reg [7:0] nxt_t2Low;
  reg [7:0] nxt_t2High;
  reg [7:0] nxt_crLow;
  reg [7:0] nxt_crHigh;
  reg [7:0] nxt_rdData;

  wire [3:0] pinVec;
  wire [3:0] pinLevel;
  wire [3:0] pinFall;

  // Machine cycle strobe, one clock in twelve
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mcCnt_ff <= {`STC_MC_CNT_W{1'b0}};
      mcTick_ff <= 1'b0;
    end
    else
    begin
      mcTick_ff <= (mcCnt_ff == MC_LAST);
      if (mcCnt_ff == MC_LAST)
        mcCnt_ff <= {`STC_MC_CNT_W{1'b0}};
      else
        mcCnt_ff <= mcCnt_ff + 1'b1;
    end
  end

  // Pin samplers, one per external input
  assign pinVec = {trigger_input_pin, timerTwoPin, external_gate_input_zero, timerZeroPin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gSampler
      stc_edge_sampler uSampler
      (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(pinVec[gi]),
        .sampleTick(mcTick_ff),
        .pinLevel(pinLevel[gi]),
        .fallEvent(pinFall[gi])
      );
    end
  endgenerate

  // Decoded control bits
  wire t2OvfFlag = second_timer_control_ff[`STC_T2_OVF];
  wire rxSrcSel = second_timer_control_ff[`STC_T2_RXSRC];
  wire txSrcSel = second_timer_control_ff[`STC_T2_TXSRC];
  wire trigEnable = second_timer_control_ff[`STC_T2_EXEN];
  wire t2RunBit = second_timer_control_ff[`STC_T2_RUN];
  wire t2CountSel = second_timer_control_ff[`STC_T2_CT];
  wire captureSel = second_timer_control_ff[`STC_T2_CPRL];
  wire baudMode = t2RunBit & (rxSrcSel | txSrcSel);
  wire captureMode = t2RunBit & ~baudMode & captureSel;
  wire reloadMode = t2RunBit & ~baudMode & ~captureSel;

  // Timer two counting and overflow
  wire t2Tick = t2RunBit & (t2CountSel ? pinFall[PIN_T2] : mcTick_ff);
  wire [15:0] t2Count = {timer_two_high_byte_ff, timer_two_low_byte_ff};
  wire t2Roll = t2Tick & (t2Count == 16'hffff);
  // Trigger ignored while clocking the serial port or stopped
  wire trigEvt = pinFall[PIN_TRIG] & trigEnable & t2RunBit & ~baudMode;
  wire doCapture = trigEvt & captureMode;
  wire doReload = (t2Roll & ~captureMode) | (trigEvt & reloadMode);

  // Timer zero split mode
  wire splitMode = (tMode_ff[`STC_TM_MODE0_HI:`STC_TM_MODE0_LO] == `STC_TM_SPLIT);
  wire t0RunBit = tCtrl_ff[`STC_TC_RUN0];
  wire t1RunBit = tCtrl_ff[`STC_TC_RUN1];
  wire gateSel = tMode_ff[`STC_TM_GATE0];
  wire t0Run = t0RunBit & (~gateSel | pinLevel[PIN_GATE0]);
  wire t0LowTick = splitMode & t0Run &
    (tMode_ff[`STC_TM_CT0] ? pinFall[PIN_T0] : mcTick_ff);
  wire t0HighTick = splitMode & t1RunBit & mcTick_ff;
  wire t0LowRoll = t0LowTick & (timer_zero_low_byte_ff == 8'hff);
  wire t0HighRoll = t0HighTick & (timer_zero_high_byte_ff == 8'hff);

  wire wrT2Ctrl = sfrWrEn & (sfrAddr == `STC_ADDR_T2CTRL);
  wire wrTCtrl = sfrWrEn & (sfrAddr == `STC_ADDR_TCTRL);
  wire wrTMode = sfrWrEn & (sfrAddr == `STC_ADDR_TMODE);

  // Timer two control; hardware set beats software clear
  always @*
  begin
    nxt_t2Ctrl = second_timer_control_ff;
    if (wrT2Ctrl)
      nxt_t2Ctrl = sfrWrData;
    if (t2Roll & ~(rxSrcSel | txSrcSel))
      nxt_t2Ctrl[`STC_T2_OVF] = 1'b1;
    if (doCapture | (trigEvt & reloadMode))
      nxt_t2Ctrl[`STC_T2_EXF] = 1'b1;
  end

  // Timer zero/one control; low and high byte overflows set flags
  always @*
  begin
    nxt_tCtrl = tCtrl_ff;
    if (wrTCtrl)
      nxt_tCtrl = {sfrWrData[7:4], 4'h0};
    if (t0LowRoll)
      nxt_tCtrl[`STC_TC_OVF0] = 1'b1;
    if (t0HighRoll)
      nxt_tCtrl[`STC_TC_OVF1] = 1'b1;
  end

  // Timer zero bytes; a software write takes precedence over counting
  always @*
  begin
    nxt_t0Low = timer_zero_low_byte_ff;
    nxt_t0High = timer_zero_high_byte_ff;
    if (t0LowTick)
      nxt_t0Low = timer_zero_low_byte_ff + 8'h01;
    if (t0HighTick)
      nxt_t0High = timer_zero_high_byte_ff + 8'h01;
    if (sfrWrEn & (sfrAddr == `STC_ADDR_T0LOW))
      nxt_t0Low = sfrWrData;
    if (sfrWrEn & (sfrAddr == `STC_ADDR_T0HIGH))
      nxt_t0High = sfrWrData;
  end

  // Timer two count, reload and capture
  always @*
  begin
    nxt_t2Low = timer_two_low_byte_ff;
    nxt_t2High = timer_two_high_byte_ff;
    nxt_crLow = capture_reload_low_ff;
    nxt_crHigh = capture_reload_high_ff;
    if (t2Tick)
      {nxt_t2High, nxt_t2Low} = t2Count + 16'h0001;
    if (doReload)
    begin
      nxt_t2Low = capture_reload_low_ff;
      nxt_t2High = capture_reload_high_ff;
    end
    if (doCapture)
    begin
      nxt_crLow = timer_two_low_byte_ff;
      nxt_crHigh = timer_two_high_byte_ff;
    end
    if (sfrWrEn & (sfrAddr == `STC_ADDR_T2LOW))
      nxt_t2Low = sfrWrData;
    if (sfrWrEn & (sfrAddr == `STC_ADDR_T2HIGH))
      nxt_t2High = sfrWrData;
    if (sfrWrEn & (sfrAddr == `STC_ADDR_CRLOW))
      nxt_crLow = sfrWrData;
    if (sfrWrEn & (sfrAddr == `STC_ADDR_CRHIGH))
      nxt_crHigh = sfrWrData;
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    nxt_rdData = rdData_ff;
    if (sfrRdEn)
    begin
      case (sfrAddr)
        `STC_ADDR_T2CTRL: nxt_rdData = second_timer_control_ff;
        `STC_ADDR_TCTRL: nxt_rdData = tCtrl_ff;
        `STC_ADDR_TMODE: nxt_rdData = {4'h0, tMode_ff};
        `STC_ADDR_T0LOW: nxt_rdData = timer_zero_low_byte_ff;
        `STC_ADDR_T0HIGH: nxt_rdData = timer_zero_high_byte_ff;
        `STC_ADDR_T2LOW: nxt_rdData = timer_two_low_byte_ff;
        `STC_ADDR_T2HIGH: nxt_rdData = timer_two_high_byte_ff;
        `STC_ADDR_CRLOW: nxt_rdData = capture_reload_low_ff;
        `STC_ADDR_CRHIGH: nxt_rdData = capture_reload_high_ff;
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  // Register state
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      second_timer_control_ff <= `STC_RST_BYTE;
      tCtrl_ff <= `STC_RST_BYTE;
      tMode_ff <= 4'h0;
      timer_zero_low_byte_ff <= `STC_RST_BYTE;
      timer_zero_high_byte_ff <= `STC_RST_BYTE;
      timer_two_low_byte_ff <= `STC_RST_BYTE;
      timer_two_high_byte_ff <= `STC_RST_BYTE;
      capture_reload_low_ff <= `STC_RST_BYTE;
      capture_reload_high_ff <= `STC_RST_BYTE;
      rdData_ff <= `STC_RST_BYTE;
    end
    else
    begin
      second_timer_control_ff <= nxt_t2Ctrl;
      tCtrl_ff <= nxt_tCtrl;
      if (wrTMode)
        tMode_ff <= sfrWrData[3:0];
      timer_zero_low_byte_ff <= nxt_t0Low;
      timer_zero_high_byte_ff <= nxt_t0High;
      timer_two_low_byte_ff <= nxt_t2Low;
      timer_two_high_byte_ff <= nxt_t2High;
      capture_reload_low_ff <= nxt_crLow;
      capture_reload_high_ff <= nxt_crHigh;
      rdData_ff <= nxt_rdData;
    end
  end

  // Registered outputs; interrupts follow the flags by one clock
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      t1RunEff_ff <= 1'b0;
      irq0_ff <= 1'b0;
      irq1_ff <= 1'b0;
      irq2_ff <= 1'b0;
      t2Ovf_ff <= 1'b0;
      rxTick_ff <= 1'b0;
      txTick_ff <= 1'b0;
    end
    else
    begin
      t1RunEff_ff <= t1RunBit & ~splitMode;
      irq0_ff <= tCtrl_ff[`STC_TC_OVF0];
      irq1_ff <= tCtrl_ff[`STC_TC_OVF1];
      irq2_ff <= t2OvfFlag | second_timer_control_ff[`STC_T2_EXF];
      t2Ovf_ff <= t2Roll;
      rxTick_ff <= rxSrcSel ? t2Roll : timerOneOverflowIn;
      txTick_ff <= txSrcSel ? t2Roll : timerOneOverflowIn;
    end
  end

  assign sfrRdData = rdData_ff;
  assign timerOneRunEff = t1RunEff_ff;
  assign irqTimerZero = irq0_ff;
  assign irqTimerOne = irq1_ff;
  assign irqTimerTwo = irq2_ff;
  assign timerTwoOverflow = t2Ovf_ff;
  assign rxBaudTick = rxTick_ff;
  assign txBaudTick = txTick_ff;
endmodule
